/* File: inc/ee_pkg.sv */
package ee_pkg;
  // ************************************************************
  // array and addressing
  // ************************************************************
  localparam int MEM_BYTES = 512;
  localparam int PAGE_BYTES = 16;
  localparam logic [2:0] DEV_CODE = 3'h5;
  localparam int LOCK_BIT = 7;
  // ************************************************************
  // register map
  // ************************************************************
  localparam int AW = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam int CTRL_POR_BIT = 0;
  localparam logic CTRL_RST = 1'b0;
  // ************************************************************
  // programming time
  // ************************************************************
  localparam int CLK_NS = 40;
  localparam int T_WR_NS = 4_000_000;
  localparam int SYNC_CYC = 8;
  localparam int CNT_W = 20;
  localparam logic [CNT_W-1:0] PROG_CYC = CNT_W'(T_WR_NS / CLK_NS - SYNC_CYC);
  // ************************************************************
  // state
  // ************************************************************
  typedef enum logic [2:0] {EE_IDLE, EE_DEV, EE_WORD, EE_WDATA, EE_RDATA, EE_RACK} ee_lst_t;
  typedef struct packed {
    logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
    logic wp_m, wp_s, por_m, por_s, done_m, done_s, done_p;
    logic [1:0] stp_m, stp_s;
    ee_lst_t st;
    logic [3:0] bits;
    logic ack, oe, id, blk, pg_id, lk_req, busy, locked, prog_t;
    logic [7:0] sh;
    logic [8:0] addr;
    logic [15:0] mask;
    logic [15:0][7:0] pbuf;
  } ee_link_t;
  typedef struct packed {
    logic pr_m, pr_s, pr_p, bs_m, bs_s, lk_m, lk_s;
    logic tmr, done_t, por, rdy, err;
    logic [CNT_W-1:0] cnt;
    logic [31:0] rd;
  } ee_sys_t;
endpackage

/* File: design/ee_slave.sv */
`timescale 1ns/1ps
// What this block does
// R01 - 512 bytes, 16-byte aligned pages
// R02 - ignore bus until power good, then standby
// R03 - after stop stay busy while programming
// R04 - write protect high blocks all writes
// R05 - write protect low allows writes
// R06 - straps compared, open strap reads zero
// R07 - data line only pulled low or released
// R08 - lockable 16-byte identification page, lock sticks
// R09 - self-timed programming within four milliseconds
// R10 - partial page writes keep other bytes
// R11 - address byte 101, page select, straps, block, direction
// R12 - written data bytes wrap within current page
// R13 - programming starts at stop after write
// R14 - no address acknowledge while programming
// R15 - standard start, stop, sampling, release
module ee_slave #(
  parameter logic [ee_pkg::CNT_W-1:0] PROG_CYCLES = ee_pkg::PROG_CYC
) (
  // system clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ee_pkg::AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // two-wire link
  input wire logic link_clk,
  input wire logic scl,
  input wire logic sda,
  output logic sda_val,
  output logic sda_en,
  // pins
  input wire logic write_protect,
  input wire logic addr_strap_low,
  input wire logic addr_strap_high
);
  // ************************************************************
  // link domain
  // ************************************************************
  ee_pkg::ee_link_t l_q;
  ee_pkg::ee_link_t l_d;
  ee_pkg::ee_sys_t s_q;
  ee_pkg::ee_sys_t s_d;
  logic [1:0] lrst_q;
  logic lrst;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic commit;
  logic dec;
  logic [7:0] rdb;
  logic [7:0] mem_q [ee_pkg::MEM_BYTES];
  logic [7:0] idp_q [ee_pkg::PAGE_BYTES];

  // reset asserts at once, releases on the link clock
  always_ff @(posedge link_clk or posedge sys_rst)
  begin
    if (sys_rst)
      lrst_q <= 2'h3;
    else
      lrst_q <= {lrst_q[0], 1'b0};
  end
  assign lrst = lrst_q[1];

  assign rise = l_q.scl_s & ~l_q.scl_p;
  assign fall = ~l_q.scl_s & l_q.scl_p;
  assign start = l_q.scl_s & l_q.scl_p & ~l_q.sda_s & l_q.sda_p; // R15
  assign stop = l_q.scl_s & l_q.scl_p & l_q.sda_s & ~l_q.sda_p; // R15
  assign commit = l_q.busy & (l_q.done_s ^ l_q.done_p);
  assign dec = l_q.por_s & ~start & ~stop & fall & ~l_q.ack & (l_q.bits == 4'h8)
    & (l_q.st == ee_pkg::EE_DEV || l_q.st == ee_pkg::EE_WORD || l_q.st == ee_pkg::EE_WDATA);
  // shared pointer: identification_page reads use its low four bits
  assign rdb = l_q.id ? idp_q[l_q.addr[3:0]] : mem_q[l_q.addr];
  assign sda_val = 1'b0; // R07
  assign sda_en = l_q.oe;

  always_comb
  begin
    l_d = l_q;
    l_d.scl_m = scl;
    l_d.scl_s = l_q.scl_m;
    l_d.scl_p = l_q.scl_s;
    l_d.sda_m = sda;
    l_d.sda_s = l_q.sda_m;
    l_d.sda_p = l_q.sda_s;
    l_d.wp_m = write_protect;
    l_d.wp_s = l_q.wp_m;
    l_d.por_m = s_q.por;
    l_d.por_s = l_q.por_m;
    l_d.done_m = s_q.done_t;
    l_d.done_s = l_q.done_m;
    l_d.done_p = l_q.done_s;
    l_d.stp_m = {addr_strap_high, addr_strap_low};
    l_d.stp_s = l_q.stp_m;
    if (commit)
    begin
      l_d.busy = 1'b0; // R03
      l_d.mask = '0;
      l_d.lk_req = 1'b0;
      if (l_q.lk_req)
        l_d.locked = 1'b1; // R08
    end
    if (!l_q.por_s)
    begin
      l_d.st = ee_pkg::EE_IDLE; // R02
      l_d.oe = 1'b0;
      l_d.ack = 1'b0;
      l_d.bits = '0;
    end
    else if (start)
    begin
      l_d.st = ee_pkg::EE_DEV;
      l_d.bits = '0;
      l_d.ack = 1'b0;
      l_d.oe = 1'b0;
      if (!l_q.busy)
      begin
        l_d.mask = '0;
        l_d.lk_req = 1'b0;
      end
    end
    else if (stop)
    begin
      l_d.st = ee_pkg::EE_IDLE;
      l_d.oe = 1'b0;
      l_d.ack = 1'b0;
      if (!l_q.busy && (|l_q.mask || l_q.lk_req))
      begin
        // protected or locked: the received bytes are dropped
        if (!l_q.wp_s && !(l_q.pg_id && l_q.locked)) // R04 R05 R08
        begin
          l_d.busy = 1'b1; // R13
          l_d.prog_t = ~l_q.prog_t;
        end
        else
        begin
          l_d.mask = '0;
          l_d.lk_req = 1'b0;
        end
      end
    end
    else if (l_q.st != ee_pkg::EE_IDLE)
    begin
      if (fall && l_q.ack)
      begin
        l_d.ack = 1'b0;
        l_d.bits = '0;
        l_d.oe = 1'b0;
        if (l_q.st == ee_pkg::EE_RDATA)
        begin
          l_d.sh = rdb;
          l_d.oe = ~rdb[7];
        end
      end
      else if (l_q.st == ee_pkg::EE_RACK)
      begin
        if (rise && l_q.sda_s)
          l_d.st = ee_pkg::EE_IDLE;
        else if (rise)
          l_d.addr = l_q.id ? {l_q.addr[8:4], l_q.addr[3:0] + 1'b1} : l_q.addr + 1'b1;
        else if (fall)
        begin
          l_d.st = ee_pkg::EE_RDATA;
          l_d.bits = '0;
          l_d.sh = rdb;
          l_d.oe = ~rdb[7];
        end
      end
      else if (l_q.st == ee_pkg::EE_RDATA)
      begin
        if (rise)
          l_d.bits = l_q.bits + 1'b1;
        else if (fall && l_q.bits == 4'h8)
        begin
          l_d.oe = 1'b0; // R15
          l_d.st = ee_pkg::EE_RACK;
        end
        else if (fall && l_q.bits != 4'h0)
        begin
          l_d.sh = {l_q.sh[6:0], 1'b0};
          l_d.oe = ~l_q.sh[6];
        end
      end
      else if (rise && l_q.bits != 4'h8)
      begin
        l_d.sh = {l_q.sh[6:0], l_q.sda_s}; // R15
        l_d.bits = l_q.bits + 1'b1;
      end
      else if (dec)
      begin
        l_d.ack = 1'b1;
        l_d.oe = 1'b1;
        case (l_q.st)
          ee_pkg::EE_DEV:
          begin
            if (l_q.sh[7:5] == ee_pkg::DEV_CODE && l_q.sh[3:2] == l_q.stp_s // R06 R11
              && !l_q.busy) // R14
            begin
              l_d.id = l_q.sh[4];
              l_d.blk = l_q.sh[1];
              l_d.st = l_q.sh[0] ? ee_pkg::EE_RDATA : ee_pkg::EE_WORD; // R11
            end
            else
            begin
              l_d.st = ee_pkg::EE_IDLE;
              l_d.ack = 1'b0;
              l_d.oe = 1'b0;
            end
          end
          ee_pkg::EE_WORD:
          begin
            l_d.st = ee_pkg::EE_WDATA;
            l_d.pg_id = l_q.id;
            if (l_q.id)
            begin
              l_d.addr[3:0] = l_q.sh[3:0];
              l_d.lk_req = l_q.sh[ee_pkg::LOCK_BIT];
            end
            else
              l_d.addr = {l_q.blk, l_q.sh};
          end
          default:
          begin
            // a lock command carries no data to program
            if (!l_q.lk_req)
            begin
              l_d.pbuf[l_q.addr[3:0]] = l_q.sh; // R10
              l_d.mask[l_q.addr[3:0]] = 1'b1; // R10
            end
            l_d.addr[3:0] = l_q.addr[3:0] + 1'b1; // R12
          end
        endcase
      end
    end
  end

  always_ff @(posedge link_clk or posedge lrst)
  begin
    if (lrst)
      l_q <= '0;
    else
      l_q <= l_d;
  end

  // array has no reset: it stands for nonvolatile cells
  always_ff @(posedge link_clk)
  begin
    if (commit)
    begin
      for (int i = 0; i < ee_pkg::PAGE_BYTES; i++)
      begin
        if (l_q.mask[i] && l_q.pg_id)
          idp_q[i] <= l_q.pbuf[i];
        else if (l_q.mask[i])
          mem_q[{l_q.addr[8:4], 4'(i)}] <= l_q.pbuf[i]; // R01
      end
    end
  end

  // ************************************************************
  // system domain: apb and programming timer
  // ************************************************************
  logic acc;

  assign acc = psel & penable & s_q.rdy;
  assign prdata = s_q.rd;
  assign pready = s_q.rdy;
  assign pslverr = s_q.err;

  always_comb
  begin
    s_d = s_q;
    s_d.pr_m = l_q.prog_t;
    s_d.pr_s = s_q.pr_m;
    s_d.pr_p = s_q.pr_s;
    s_d.bs_m = l_q.busy;
    s_d.bs_s = s_q.bs_m;
    s_d.lk_m = l_q.locked;
    s_d.lk_s = s_q.lk_m;
    s_d.rdy = 1'b0;
    s_d.err = 1'b0;
    // zero wait state: ready in the first access cycle
    if (psel && !penable)
    begin
      s_d.rdy = 1'b1;
      if (paddr == ee_pkg::REG_CTRL)
        s_d.rd = {31'h0000_0000, s_q.por};
      else if (paddr == ee_pkg::REG_STAT)
        s_d.rd = {29'h0000_0000, s_q.tmr, s_q.lk_s, s_q.bs_s};
      else
      begin
        s_d.rd = 32'h0000_0000;
        s_d.err = 1'b1;
      end
    end
    if (acc && pwrite && pstrb[0] && paddr == ee_pkg::REG_CTRL)
      s_d.por = pwdata[ee_pkg::CTRL_POR_BIT];
    // link clock may be slow, so the count runs here
    if (s_q.pr_s != s_q.pr_p)
    begin
      s_d.tmr = 1'b1; // R09
      s_d.cnt = PROG_CYCLES - 1'b1;
    end
    else if (s_q.tmr && s_q.cnt == '0)
    begin
      s_d.tmr = 1'b0; // R09
      s_d.done_t = ~s_q.done_t;
    end
    else if (s_q.tmr)
      s_d.cnt = s_q.cnt - 1'b1;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // ************************************************************
  // checks
  // ************************************************************
  a_por_gate: assert property ( // R02
    @(posedge link_clk) disable iff (lrst)
    !l_q.por_s |=> !l_q.oe && l_q.st == ee_pkg::EE_IDLE)
    else $error("bus not ignored without power good");
  a_stop_busy: assert property ( // R03
    @(posedge link_clk) disable iff (lrst)
    stop && l_q.busy && !commit |=> l_q.busy)
    else $error("busy lost at stop");
  a_wp_block: assert property ( // R04
    @(posedge link_clk) disable iff (lrst)
    stop && l_q.wp_s |=> $stable(l_q.prog_t))
    else $error("programming under write protect");
  a_strap_check: assert property ( // R06
    @(posedge link_clk) disable iff (lrst)
    dec && l_q.st == ee_pkg::EE_DEV && l_q.sh[3:2] != l_q.stp_s |=> !l_q.oe)
    else $error("ack despite strap mismatch");
  a_lock_sticky: assert property ( // R08
    @(posedge link_clk) disable iff (lrst)
    l_q.locked |=> l_q.locked)
    else $error("lock released");
  a_timer_end: assert property ( // R09
    @(posedge clk) disable iff (sys_rst)
    s_q.tmr && s_q.cnt == '0 |=> !s_q.tmr && s_q.done_t != $past(s_q.done_t))
    else $error("timer did not finish");
  a_page_wrap: assert property ( // R12
    @(posedge link_clk) disable iff (lrst)
    dec && l_q.st == ee_pkg::EE_WDATA |=> l_q.addr[8:4] == $past(l_q.addr[8:4])
      && l_q.addr[3:0] == $past(l_q.addr[3:0]) + 4'h1)
    else $error("page pointer wrong");
  a_prog_start: assert property ( // R13
    @(posedge link_clk) disable iff (lrst)
    stop && l_q.por_s && !l_q.busy && |l_q.mask && !l_q.wp_s && !l_q.pg_id
      |=> l_q.busy && l_q.prog_t != $past(l_q.prog_t))
    else $error("no programming after stop");
  a_busy_nack: assert property ( // R14
    @(posedge link_clk) disable iff (lrst)
    dec && l_q.st == ee_pkg::EE_DEV && l_q.busy |=> !l_q.oe ##1 !l_q.ack)
    else $error("address acked while busy");
  c_commit: cover property (@(posedge link_clk) disable iff (lrst) commit);
  c_read_ack: cover property (
    @(posedge link_clk) disable iff (lrst) l_q.st == ee_pkg::EE_RACK && rise && !l_q.sda_s);
  c_busy_poll: cover property (
    @(posedge link_clk) disable iff (lrst) dec && l_q.st == ee_pkg::EE_DEV && l_q.busy);
  c_apb_write: cover property (@(posedge clk) disable iff (sys_rst) acc && pwrite);
endmodule

/* File: testbench/ee_host.sv */
`timescale 1ns/1ps
module ee_host (
  // two-wire side
  input wire logic link_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_pull,
  // one result per byte: {ninth bit, eight bits seen}
  output logic [8:0] res,
  output logic res_stb
);
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
    res = 9'h000;
    res_stb = 1'b0;
  end
  // ****************************************
  // bit timing: 5 link clocks a phase, so setup and hold stay above 4
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(posedge link_clk);
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_pull <= ~b;
    tick(5);
    scl <= 1'b1;
    tick(5);
    r = sda;
    scl <= 1'b0;
    tick(5);
  endtask
  task automatic start_c();
    sda_pull <= 1'b0;
    tick(5);
    scl <= 1'b1;
    tick(5);
    sda_pull <= 1'b1;
    tick(5);
    scl <= 1'b0;
    tick(5);
  endtask
  task automatic stop_c();
    sda_pull <= 1'b1;
    tick(5);
    scl <= 1'b1;
    tick(5);
    sda_pull <= 1'b0;
    tick(5);
  endtask
  // msb first; clock stands high outside frames
  task automatic xfer(input logic [7:0] tx, input logic mack);
    logic [8:0] r;
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], r[i]);
    bit_io(mack, r[8]);
    res <= r;
    res_stb <= 1'b1;
    tick(1);
    res_stb <= 1'b0;
  endtask
endmodule

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_count++; \
  $display("unexpected at %0t: got %h want %h", $time, (a), (e)); end end
module testbench;
  localparam int PROG = 200;
  logic clk, link_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [ee_pkg::AW-1:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic scl, sda, sda_val, sda_en, pull, wp, strap_lo, strap_hi, res_stb;
  logic [8:0] res, le;
  logic [7:0] dev;
  logic [32:0] ae;
  logic [7:0] mem [512];
  logic [32:0] aq [$];
  logic [8:0] lq [$];
  int err_count, check_count;
  // open drain line with pull-up
  assign sda = (sda_en | pull) ? 1'b0 : 1'b1;
  ee_slave #(.PROG_CYCLES(20'h0_00c8)) uut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_clk(link_clk), .scl(scl),
    .sda(sda), .sda_val(sda_val), .sda_en(sda_en), .write_protect(wp),
    .addr_strap_low(strap_lo), .addr_strap_high(strap_hi));
  ee_host host (.link_clk(link_clk), .sda(sda), .scl(scl), .sda_pull(pull), .res(res),
    .res_stb(res_stb));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    link_clk = 1'b0;
    #3;
    forever #6 link_clk = ~link_clk;
  end
  // ****************************************
  // result watchers
  // ****************************************
  always @(posedge clk)
  begin
    if (psel && penable && pready && !pwrite && aq.size() > 0)
    begin
      ae = aq.pop_front();
      `CHK({pslverr, prdata}, ae)
    end
  end
  always @(posedge link_clk)
  begin
    if (sda_en === 1'b1)
      `CHK(sda_val, 1'b0)
    if (res_stb && lq.size() > 0)
    begin
      le = lq.pop_front();
      `CHK(res, le)
    end
  end
  // ****************************************
  // drivers
  // ****************************************
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic complete_run();
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    input logic [32:0] e);
    int n;
    n = 0;
    if (!wr)
      aq.push_back(e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (n >= 16)
    begin
      err_count++;
      complete_run();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic xb(input logic [7:0] tx, input logic mack, input logic [8:0] e);
    lq.push_back(e);
    host.xfer(tx, mack);
  endtask
  // lone address byte, ack or nack expected
  task automatic probe(input logic [7:0] a, input logic nak);
    host.start_c();
    xb(a, 1'b1, {nak, a});
    host.stop_c();
  endtask
  task automatic mwr(input logic b, input logic [7:0] wa, input int n, input logic ok);
    logic [7:0] d;
    host.start_c();
    xb(dev | {6'h00, b, 1'b0}, 1'b1, {1'b0, dev | {6'h00, b, 1'b0}});
    xb(wa, 1'b1, {1'b0, wa});
    for (int i = 0; i < n; i++)
    begin
      d = 8'(xs());
      xb(d, 1'b1, {1'b0, d});
      if (ok)
        mem[{b, wa[7:4], 4'(wa[3:0] + i)}] = d;
    end
    host.stop_c();
  endtask
  task automatic mrd(input logic b, input logic [7:0] wa, input int n);
    logic [8:0] p;
    p = {b, wa};
    host.start_c();
    xb(dev | {6'h00, b, 1'b0}, 1'b1, {1'b0, dev | {6'h00, b, 1'b0}});
    xb(wa, 1'b1, {1'b0, wa});
    host.start_c();
    xb(dev | {6'h00, b, 1'b1}, 1'b1, {1'b0, dev | {6'h00, b, 1'b1}});
    for (int i = 0; i < n; i++)
    begin
      xb(8'hff, i == n - 1, {i == n - 1, mem[p]});
      p++;
    end
    host.stop_c();
  endtask
  // busy with timer after stop, refused address, then done within the count
  task automatic commit(input logic [31:0] fin);
    repeat (6) @(posedge clk);
    apb(1'b0, ee_pkg::REG_STAT, 32'h0000_0000, {1'b0, 32'h0000_0005});
    probe(dev, 1'b1);
    repeat (PROG) @(posedge clk);
    apb(1'b0, ee_pkg::REG_STAT, 32'h0000_0000, {1'b0, fin});
    probe(dev, 1'b0);
  endtask
  initial
  begin
    repeat (90000) @(posedge clk);
    err_count++;
    complete_run();
  end
  initial
  begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    wp = 1'b0;
    strap_lo = 1'b0;
    strap_hi = 1'b0;
    seed = 32'h0000_0740;
    err_count = 0;
    check_count = 0;
    dev = 8'ha0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    apb(1'b0, ee_pkg::REG_CTRL, 32'h0000_0000, {1'b0, 32'h0000_0000});
    apb(1'b0, 8'h08, 32'h0000_0000, {1'b1, 32'h0000_0000});
    probe(dev, 1'b1);
    apb(1'b1, ee_pkg::REG_CTRL, 32'h0000_0001, {1'b0, 32'h0000_0000});
    apb(1'b0, ee_pkg::REG_CTRL, 32'h0000_0000, {1'b0, 32'h0000_0001});
    strap_hi <= 1'b1;
    repeat (8) @(posedge clk);
    probe(dev, 1'b1);
    dev = 8'ha8;
    mwr(1'b0, 8'h23, 1, 1'b1);
    commit(32'h0000_0000);
    mwr(1'b1, 8'h5e, 18, 1'b1);
    commit(32'h0000_0000);
    mwr(1'b1, 8'h5f, 2, 1'b1);
    commit(32'h0000_0000);
    mrd(1'b1, 8'h50, 16);
    mrd(1'b0, 8'h23, 1);
    // identification_page: lock it, then a write to it must start nothing
    host.start_c();
    xb(dev | 8'h10, 1'b1, {1'b0, dev | 8'h10});
    xb(8'h80, 1'b1, 9'h080);
    host.stop_c();
    commit(32'h0000_0002);
    host.start_c();
    xb(dev | 8'h10, 1'b1, {1'b0, dev | 8'h10});
    xb(8'h01, 1'b1, 9'h001);
    xb(8'h55, 1'b1, 9'h055);
    host.stop_c();
    repeat (6) @(posedge clk);
    apb(1'b0, ee_pkg::REG_STAT, 32'h0000_0000, {1'b0, 32'h0000_0002});
    wp <= 1'b1;
    repeat (4) @(posedge clk);
    mwr(1'b1, 8'h55, 1, 1'b0);
    repeat (6) @(posedge clk);
    apb(1'b0, ee_pkg::REG_STAT, 32'h0000_0000, {1'b0, 32'h0000_0002});
    mrd(1'b1, 8'h50, 16);
    complete_run();
  end
endmodule
